/* hdl/battery_if.sv */
// link between the sequencer and its battery hysteresis tracker
`timescale 1ns/1ps
interface battery_if;
    logic low_cmp;   // synced: battery below selected threshold
    logic ok_cmp;    // synced: battery above threshold plus hysteresis
    logic below;     // tracked low-battery condition

    modport seq (output low_cmp, output ok_cmp, input below);
    modport mon (input low_cmp, input ok_cmp, output below);
endinterface : battery_if

/* hdl/battery_tracker.sv */
// hysteresis tracker for the battery critical-level comparators
`timescale 1ns/1ps
module battery_tracker (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // comparator link
    battery_if.mon   bat
);

    logic below_q;
    logic below_d;

    // enter on the low trip, leave only above the hysteresis band
    assign below_d = bat.low_cmp ? 1'b1
                   : (bat.ok_cmp ? 1'b0 : below_q);
    assign bat.below = below_q;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            below_q <= reset_seq_pkg::below_reset;
        end else begin
            below_q <= below_d;
        end
    end

    // hold the flag while inside the hysteresis band
    property p_band_hold;
        @(posedge clock) disable iff (!reset_n)
        (below_q && !bat.ok_cmp && !bat.low_cmp) |=> below_q;
    endproperty
    a_band_hold: assert property (p_band_hold)
        else $error("low flag dropped inside hysteresis band");

endmodule : battery_tracker

/* hdl/reset_seq_pkg.sv */
// shared constants and types for the reset and battery monitor sequencer
package reset_seq_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        st_shutdown = 2'b00,  // chip enable low, full power down
        st_monitor  = 2'b01,  // battery below critical level
        st_load     = 2'b10,  // nonvolatile defaults being fetched
        st_run      = 2'b11   // firmware released
    } seq_state_type;

    // reset values
    localparam seq_state_type state_reset    = st_shutdown;
    localparam logic          mon_en_reset   = 1'b0;
    localparam logic          thr_sel_reset  = 1'b0;
    localparam logic          below_reset    = 1'b0;

    // interface select pin field
    localparam int            if_sel_width   = 2;
    localparam logic [1:0]    if_sel_reset   = 2'h0;

    // threshold select encoding driven to the comparator
    localparam logic          thr_sel_low    = 1'b0;  // 2.3 V level
    localparam logic          thr_sel_high   = 1'b1;  // 2.75 V level

    // synchroniser depth for pin inputs
    localparam int            sync_stages    = 2;

endpackage : reset_seq_pkg

/* hdl/reset_sequencer.sv */
// reset entry and exit sequencer with battery monitor control
`timescale 1ns/1ps
module reset_sequencer (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // pins from outside the clock domain
    input  wire logic       chip_enable_pin,
    input  wire logic       pad_supply_good,
    input  wire logic [1:0] if_select_pins,
    // battery comparators, referenced to the selected level
    input  wire logic       vbat_low_cmp,
    input  wire logic       vbat_ok_cmp,
    // nonvolatile default loader
    output logic            nv_load_req,
    input  wire logic       nv_load_done,
    input  wire logic       nv_monitor_enable,
    input  wire logic       nv_threshold_high,
    // outputs to the core
    output logic            core_reset_n,
    output logic            monitor_enable,
    output logic            threshold_select,
    output logic [1:0]      if_select,
    output logic            pad_supply_lost,
    output logic [1:0]      seq_state
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    localparam int n_sync = 5;
    logic [n_sync-1:0] raw_in;
    logic [n_sync-1:0] meta_q;
    logic [n_sync-1:0] sync_q;

    assign raw_in = {chip_enable_pin, pad_supply_good, if_select_pins,
                     vbat_low_cmp};

    // two flops per pin before any logic looks at it
    genvar gi;
    generate
        for (gi = 0; gi < n_sync; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= raw_in[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    logic ok_meta_q;
    logic ok_sync_q;

    // ok comparator resets low like the other synchronisers; the low flag
    // also resets clear, so nothing trips before the pins have settled
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ok_meta_q <= 1'b0;
            ok_sync_q <= 1'b0;
        end else begin
            ok_meta_q <= vbat_ok_cmp;
            ok_sync_q <= ok_meta_q;
        end
    end

    wire       ce_s    = sync_q[4];
    wire       pad_s   = sync_q[3];
    wire [1:0] sel_s   = sync_q[2:1];

    ////////////////////////////////////////////////////////////////////////
    // battery hysteresis tracker

    battery_if bat ();
    assign bat.low_cmp = sync_q[0];
    assign bat.ok_cmp  = ok_sync_q;

    battery_tracker u_tracker (
        .clock   (clock),
        .reset_n (reset_n),
        .bat     (bat)
    );

    ////////////////////////////////////////////////////////////////////////
    // state machine

    reset_seq_pkg::seq_state_type state_q;
    reset_seq_pkg::seq_state_type state_d;
    logic       mon_en_q;
    logic       mon_en_d;
    logic       thr_q;
    logic       thr_d;
    logic [1:0] if_sel_q;
    logic [1:0] if_sel_d;
    logic       run_q;
    logic       lost_q;
    logic       lost_d;

    // battery trip only counts when the monitor is on
    wire bat_trip  = mon_en_q && bat.below;
    wire load_trip = nv_monitor_enable && bat.below;
    wire load_done = (state_q == reset_seq_pkg::st_load) && nv_load_done;

    always_comb begin
        state_d  = state_q;
        mon_en_d = mon_en_q;
        thr_d    = thr_q;
        if_sel_d = if_sel_q;
        if (!ce_s) begin
            state_d  = reset_seq_pkg::st_shutdown;
            mon_en_d = reset_seq_pkg::mon_en_reset;
        end else begin
            case (state_q)
                reset_seq_pkg::st_shutdown: begin
                    state_d = reset_seq_pkg::st_load;
                end
                reset_seq_pkg::st_load: begin
                    if (nv_load_done) begin
                        mon_en_d = nv_monitor_enable;
                        thr_d    = nv_threshold_high;
                        if_sel_d = sel_s;
                        // pad supply is not waited for
                        state_d  = load_trip ? reset_seq_pkg::st_monitor
                                             : reset_seq_pkg::st_run;
                    end
                end
                reset_seq_pkg::st_run: begin
                    if (bat_trip) begin
                        state_d = reset_seq_pkg::st_monitor;
                    end
                end
                reset_seq_pkg::st_monitor: begin
                    if (!bat.below) begin
                        state_d = reset_seq_pkg::st_load;
                    end
                end
                default: state_d = reset_seq_pkg::st_shutdown;
            endcase
        end
    end

    // pad loss while running is remembered until the next boot
    assign lost_d = (state_q == reset_seq_pkg::st_load) ? 1'b0
                  : (lost_q || (run_q && !pad_s));

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q  <= reset_seq_pkg::state_reset;
            mon_en_q <= reset_seq_pkg::mon_en_reset;
            thr_q    <= reset_seq_pkg::thr_sel_reset;
            if_sel_q <= reset_seq_pkg::if_sel_reset;
            run_q    <= 1'b0;
            lost_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            mon_en_q <= mon_en_d;
            thr_q    <= thr_d;
            if_sel_q <= if_sel_d;
            run_q    <= (state_d == reset_seq_pkg::st_run);
            lost_q   <= lost_d;
        end
    end

    // outputs
    assign nv_load_req      = (state_q == reset_seq_pkg::st_load);
    assign core_reset_n     = run_q;
    assign monitor_enable   = mon_en_q;
    assign threshold_select = thr_q;
    assign if_select        = if_sel_q;
    assign pad_supply_lost  = lost_q;
    assign seq_state        = state_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_ce_low;
        @(posedge clock) disable iff (!reset_n)
        !ce_s |=> (state_q == reset_seq_pkg::st_shutdown) && !run_q;
    endproperty
    a_ce_low: assert property (p_ce_low)
        else $error("enable low did not force shutdown");

    property p_bat_trip;
        @(posedge clock) disable iff (!reset_n)
        (ce_s && state_q == reset_seq_pkg::st_run && bat_trip)
            |=> (state_q == reset_seq_pkg::st_monitor) && !core_reset_n;
    endproperty
    a_bat_trip: assert property (p_bat_trip)
        else $error("low battery did not enter monitor");

    property p_run_via_load;
        @(posedge clock) disable iff (!reset_n)
        $rose(run_q) |-> $past(state_q) == reset_seq_pkg::st_load;
    endproperty
    a_run_via_load: assert property (p_run_via_load)
        else $error("release without default reload");

    property p_exit_cond;
        @(posedge clock) disable iff (!reset_n)
        $rose(run_q) |-> $past(ce_s) && !$past(load_trip);
    endproperty
    a_exit_cond: assert property (p_exit_cond)
        else $error("released without enable or battery");

    property p_mon_off;
        @(posedge clock) disable iff (!reset_n)
        !ce_s |=> !monitor_enable;
    endproperty
    a_mon_off: assert property (p_mon_off)
        else $error("monitor on after power down");

    property p_thr_load;
        @(posedge clock) disable iff (!reset_n)
        (ce_s && load_done) |=>
            threshold_select == $past(nv_threshold_high)
            && monitor_enable == $past(nv_monitor_enable);
    endproperty
    a_thr_load: assert property (p_thr_load)
        else $error("nonvolatile settings not taken");

    property p_pad_free;
        @(posedge clock) disable iff (!reset_n)
        (ce_s && load_done && !load_trip) |=> run_q;
    endproperty
    a_pad_free: assert property (p_pad_free)
        else $error("boot waited on pad supply");

    sequence s_ce_cycle;
        !ce_s ##1 ce_s;
    endsequence
    sequence s_reboot;
        nv_load_req ##0 !core_reset_n;
    endsequence
    property p_reboot;
        @(posedge clock) disable iff (!reset_n)
        s_ce_cycle |=> s_reboot;
    endproperty
    a_reboot: assert property (p_reboot)
        else $error("enable cycle gave no fresh boot");

endmodule : reset_sequencer

/* testbench/battery_monitor_reset_sequencer_tb_top.sv */
// self-checking bench for the reset and battery monitor sequencer
`timescale 1ns/1ps
module battery_monitor_reset_sequencer_tb_top;
    logic       clock, reset_n, chip_enable_pin, pad_supply_good;
    logic [1:0] if_select_pins, if_select, seq_state, s;
    logic       vbat_low_cmp, vbat_ok_cmp, nv_load_req, nv_load_done;
    logic       nv_monitor_enable, nv_threshold_high, core_reset_n;
    logic       monitor_enable, threshold_select, pad_supply_lost;
    logic       cfg_monitor, cfg_thr_high, m, t;
    logic [3:0] cfg_delay, d;
    int         failures, samples_checked, seed;

    reset_sequencer dut (
        .clock(clock), .reset_n(reset_n), .chip_enable_pin(chip_enable_pin),
        .pad_supply_good(pad_supply_good), .if_select_pins(if_select_pins),
        .vbat_low_cmp(vbat_low_cmp), .vbat_ok_cmp(vbat_ok_cmp),
        .nv_load_req(nv_load_req), .nv_load_done(nv_load_done),
        .nv_monitor_enable(nv_monitor_enable),
        .nv_threshold_high(nv_threshold_high), .core_reset_n(core_reset_n),
        .monitor_enable(monitor_enable), .threshold_select(threshold_select),
        .if_select(if_select), .pad_supply_lost(pad_supply_lost),
        .seq_state(seq_state));

    nv_store_model store (
        .clock(clock), .reset_n(reset_n), .cfg_monitor(cfg_monitor),
        .cfg_thr_high(cfg_thr_high), .cfg_delay(cfg_delay),
        .nv_load_req(nv_load_req), .nv_load_done(nv_load_done),
        .nv_monitor_enable(nv_monitor_enable),
        .nv_threshold_high(nv_threshold_high));

    ////////////////////////////////////////////////////////////////////////
    // compare one value and count it
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // settle just after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // bounded wait for a state, then compare it
    task automatic wait_state(input logic [1:0] exp);
        int k;
        k = 0;
        while (seq_state !== exp && k < 40) begin
            step(1);
            k++;
        end
        check("seq_state", {6'h00, seq_state}, {6'h00, exp});
    endtask : wait_state

    // state expected after boot or a battery drop
    function automatic logic [1:0] run_state(input logic mon, input logic lo);
        return (mon && lo) ? 2'h1 : 2'h3;
    endfunction : run_state

    // raise enable with the battery good and follow the boot
    task automatic boot(input logic mon, input logic thr,
                        input logic [1:0] sp, input logic [3:0] dl);
        cfg_monitor = mon;
        cfg_thr_high = thr;
        cfg_delay = dl;
        if_select_pins = sp;
        chip_enable_pin = 1'b1;
        wait_state(2'h2);
        check("nv_load_req", {7'h00, nv_load_req}, 8'h01);
        wait_state(2'h3);
        check("core_reset_n", {7'h00, core_reset_n}, 8'h01);
        check("monitor_enable", {7'h00, monitor_enable}, {7'h00, mon});
        check("thr_select", {7'h00, threshold_select}, {7'h00, thr});
        check("if_select", {6'h00, if_select}, {6'h00, sp});
    endtask : boot

    // pull enable low and expect full shutdown three edges later
    task automatic drop();
        chip_enable_pin = 1'b0;
        step(3);
        check("seq_state", {6'h00, seq_state}, 8'h00);
        check("core_reset_n", {7'h00, core_reset_n}, 8'h00);
        check("monitor_enable", {7'h00, monitor_enable}, 8'h00);
    endtask : drop

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        conclude();
    end

    // main sequence
    initial begin
        reset_n = 1'b0;
        chip_enable_pin = 1'b0;
        pad_supply_good = 1'b0;
        if_select_pins = 2'h0;
        vbat_low_cmp = 1'b0;
        vbat_ok_cmp = 1'b1;
        cfg_monitor = 1'b0;
        cfg_thr_high = 1'b0;
        cfg_delay = 4'h0;
        seed = $urandom(60417);
        step(5);
        reset_n = 1'b1;
        check("seq_state", {6'h00, seq_state}, 8'h00);
        check("core_reset_n", {7'h00, core_reset_n}, 8'h00);
        check("monitor_enable", {7'h00, monitor_enable}, 8'h00);
        check("nv_load_req", {7'h00, nv_load_req}, 8'h00);
        $display("test reset done");
        boot(1'b0, 1'b0, 2'h2, 4'h0);
        pad_supply_good = 1'b1;
        drop();
        $display("test supply order done");
        for (int i = 0; i < 8; i++) begin
            m = 1'($urandom_range(0, 1));
            t = 1'($urandom_range(0, 1));
            s = 2'($urandom_range(0, 3));
            d = 4'($urandom_range(0, 7));
            boot(m, t, s, d);
            vbat_low_cmp = 1'b1;
            vbat_ok_cmp = 1'b0;
            step(6);
            check("seq_state", {6'h00, seq_state}, {6'h00, run_state(m, 1'b1)});
            check("core_reset_n", {7'h00, core_reset_n}, {7'h00, ~m});
            vbat_low_cmp = 1'b0;
            step(6);
            check("seq_state", {6'h00, seq_state}, {6'h00, run_state(m, 1'b1)});
            vbat_ok_cmp = 1'b1;
            if (m) begin
                wait_state(2'h2);
                wait_state(2'h3);
            end
            drop();
        end
        $display("test battery done");
        boot(1'b0, 1'b1, 2'h1, 4'h3);
        pad_supply_good = 1'b0;
        step(4);
        check("pad_lost", {7'h00, pad_supply_lost}, 8'h01);
        pad_supply_good = 1'b1;
        drop();
        boot(1'b1, 1'b0, 2'h3, 4'h7);
        check("pad_lost", {7'h00, pad_supply_lost}, 8'h00);
        drop();
        $display("test pad reboot done");
        cfg_delay = 4'hf;
        chip_enable_pin = 1'b1;
        wait_state(2'h2);
        drop();
        $display("test abort load done");
        conclude();
    end
endmodule : battery_monitor_reset_sequencer_tb_top

/* testbench/nv_store_model.sv */
// nonvolatile settings store that answers the sequencer's load requests
`timescale 1ns/1ps
module nv_store_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // settings held in the store and answer delay
    input  wire logic       cfg_monitor,
    input  wire logic       cfg_thr_high,
    input  wire logic [3:0] cfg_delay,
    // load handshake
    input  wire logic       nv_load_req,
    output logic            nv_load_done,
    output logic            nv_monitor_enable,
    output logic            nv_threshold_high
);
    logic [3:0] wait_q;

    ////////////////////////////////////////////////////////////////////////
    // answer a request after cfg_delay + 1 cycles with a one cycle done pulse
    always @(posedge clock) begin
        if (!reset_n || !nv_load_req || nv_load_done) begin
            wait_q <= 4'h0;
            nv_load_done <= 1'b0;
        end else if (wait_q >= cfg_delay) begin
            nv_load_done <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end

    // settings are valid only with done, garbage otherwise
    assign nv_monitor_enable = nv_load_done ? cfg_monitor : ~cfg_monitor;
    assign nv_threshold_high = nv_load_done ? cfg_thr_high : ~cfg_thr_high;
endmodule : nv_store_model
